// *** hdl/iic_card.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - eight independent channels, each own settings
// - evaluate channels once per 5 ms scan
// - thresholds settable at 0.1 V resolution
// - sense select, default normally open
// - pickup hold delays 0-to-1 change
// - dropout hold delays 1-to-0 change
// - alternating option adds 30 ms dropout
// - alternating option forces dropout to 10%
// - 32-bit rising tally per channel
// - clear command zeros the channel tally, except in a cycle with a rise, which wins
// - report live channel voltage in millivolts
// - thresholds stored separately per channel
// - channel numbers follow earlier card inputs
// - state usable within one further scan
module iic_card #(
   parameter int unsigned N = iic_pkg::CHANNELS,
   parameter int unsigned SCAN_PERIOD = iic_pkg::SCAN_CYCLES,
   parameter int unsigned FIRST_INDEX = 0
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [N*iic_pkg::MV_W-1:0] channel_mv_i,
   input wire iic_pkg::iic_cfg_type [N-1:0] cfg_i,
   input wire logic [N-1:0] tally_reset_command_i,
   output logic [N-1:0] input_channel_n_o,
   output logic [N-1:0] rise_o,
   output logic [N*iic_pkg::MV_W-1:0] live_channel_voltage_o,
   output logic [N*iic_pkg::TALLY_W-1:0] rising_edge_tally_o,
   output logic [7:0] first_channel_number_o,
   output logic scan_tick_o
);
   import iic_pkg::*;
   initial begin
      if (N != CHANNELS) $error("card has eight channels");
      if (FIRST_INDEX > 247) $error("channel number range");
   end
   logic tick;
   logic [N*MV_W-1:0] mv_s1_q, mv_s2_q;
   logic [N-1:0] clr_s1_q, clr_s2_q;
   iic_stat_type [N-1:0] stat;

   // two-stage capture of off-domain inputs
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mv_s1_q <= '0;
         mv_s2_q <= '0;
         clr_s1_q <= '0;
         clr_s2_q <= '0;
      end else begin
         mv_s1_q <= channel_mv_i;
         mv_s2_q <= mv_s1_q;
         clr_s1_q <= tally_reset_command_i;
         clr_s2_q <= clr_s1_q;
      end
   end

   iic_scan_timer #(.PERIOD(SCAN_PERIOD)) u_timer (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .tick_o(tick)
   );

   for (genvar g = 0; g < N; g++) begin : g_ch
      iic_channel u_ch (
         .mclk_i(mclk_i),
         .arst_n_i(arst_n_i),
         .tick_i(tick),
         .mv_i(mv_s2_q[g*MV_W +: MV_W]),
         .cfg_i(cfg_i[g]),
         .tally_reset_command_i(clr_s2_q[g]),
         .stat_o(stat[g]),
         .rising_edge_tally_o(rising_edge_tally_o[g*TALLY_W +: TALLY_W])
      );
      assign input_channel_n_o[g] = stat[g].state;
      assign rise_o[g] = stat[g].rise;
      assign live_channel_voltage_o[g*MV_W +: MV_W] = stat[g].live_channel_voltage;
   end

   assign first_channel_number_o = 8'(FIRST_INDEX + 1);
   assign scan_tick_o = tick;

   a_tick_single: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tick |=> !tick) else $error("tick longer than one cycle");
endmodule : iic_card

// *** hdl/iic_channel.sv ***
`timescale 1ns/10ps
module iic_channel (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic tick_i,
   input wire logic [iic_pkg::MV_W-1:0] mv_i,
   input wire iic_pkg::iic_cfg_type cfg_i,
   input wire logic tally_reset_command_i,
   output iic_pkg::iic_stat_type stat_o,
   output logic [iic_pkg::TALLY_W-1:0] rising_edge_tally_o
);
   import iic_pkg::*;
   localparam int unsigned AC_TICKS = AC_EXTRA_MS / SCAN_MS;

   // volts in 0.1 V steps scaled to millivolts
   function automatic logic [MV_W-1:0] dv_to_mv(input logic [VOLT_W-1:0] dv);
      dv_to_mv = MV_W'(dv) * MV_W'(100);
   endfunction : dv_to_mv

   // millisecond hold to scan ticks, rounded up
   function automatic logic [HOLD_W-1:0] ms_to_ticks(input logic [HOLD_W-1:0] ms);
      ms_to_ticks = HOLD_W'((ms + HOLD_W'(SCAN_MS - 1)) / HOLD_W'(SCAN_MS));
   endfunction : ms_to_ticks

   logic raw_q, raw_d, state_q, state_d, rise_q, rise_d;
   logic [HOLD_W-1:0] wait_q, wait_d;
   logic [MV_W-1:0] mv_q, mv_d;
   logic [TALLY_W-1:0] tally_q, tally_d;
   logic [MV_W-1:0] on_mv, off_mv;
   logic hi, lo;
   logic [HOLD_W-1:0] need;

   always_comb begin
      on_mv = dv_to_mv(cfg_i.pickup_voltage_level);
      off_mv = cfg_i.alternating_supply_option ? MV_W'(on_mv / MV_W'(10))
                                               : dv_to_mv(cfg_i.dropout_voltage_level);
      hi = mv_i > on_mv;
      lo = mv_i < off_mv;
      raw_d = raw_q;
      mv_d = mv_q;
      state_d = state_q;
      wait_d = wait_q;
      rise_d = 1'b0;
      need = HOLD_W'(0);
      if (tick_i) begin
         mv_d = mv_i;
         if (hi) begin
            raw_d = ~cfg_i.channel_sense_select;
         end else if (lo) begin
            raw_d = cfg_i.channel_sense_select;
         end
         if (raw_d == state_q) begin
            wait_d = HOLD_W'(0);
         end else begin
            if (raw_d) begin
               need = ms_to_ticks(cfg_i.pickup_hold_time);
            end else begin
               need = ms_to_ticks(cfg_i.dropout_hold_time)
                      + (cfg_i.alternating_supply_option ? HOLD_W'(AC_TICKS) : HOLD_W'(0));
            end
            if (wait_q >= need) begin
               state_d = raw_d;
               rise_d = raw_d;
               wait_d = HOLD_W'(0);
            end else begin
               wait_d = wait_q + HOLD_W'(1);
            end
         end
      end
      if (rise_d) begin
         tally_d = tally_q + TALLY_W'(1);
      end else if (tally_reset_command_i) begin
         tally_d = TALLY_RESET;
      end else begin
         tally_d = tally_q;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         raw_q <= 1'b0;
         state_q <= 1'b0;
         rise_q <= 1'b0;
         wait_q <= HOLD_RESET;
         mv_q <= '0;
         tally_q <= TALLY_RESET;
      end else begin
         raw_q <= raw_d;
         state_q <= state_d;
         rise_q <= rise_d;
         wait_q <= wait_d;
         mv_q <= mv_d;
         tally_q <= tally_d;
      end
   end

   assign stat_o.state = state_q;
   assign stat_o.rise = rise_q;
   assign stat_o.live_channel_voltage = mv_q;
   assign rising_edge_tally_o = tally_q;

   a_state_on_tick: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !$past(tick_i) |-> $stable(state_q)) else $error("state moved off tick");
   a_rise_counts: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      rise_q |-> tally_q == $past(tally_q) + TALLY_W'(1)) else $error("tally missed rise");
   a_clear_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tally_reset_command_i && !rise_d |=> tally_q == TALLY_RESET) else $error("clear failed");
   a_rise_is_edge: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      rise_q |-> state_q && !$past(state_q)) else $error("rise without edge");
   a_band_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tick_i && !hi && !lo |=> raw_q == $past(raw_q)) else $error("raw moved in band");
   a_hi_sense: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tick_i && hi |=> raw_q == !$past(cfg_i.channel_sense_select)) else $error("bad hi");
   a_lo_sense: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tick_i && !hi && lo |=> raw_q == $past(cfg_i.channel_sense_select)) else $error("bad lo");
   a_ac_release: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      cfg_i.alternating_supply_option |-> off_mv == on_mv / MV_W'(10)) else $error("ac level");
   a_voltage_tick: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tick_i |=> mv_q == $past(mv_i)) else $error("voltage not sampled");
endmodule : iic_channel

// *** hdl/iic_pkg.sv ***
package iic_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SCAN_MS = 5;
   localparam int unsigned SCAN_CYCLES = CLK_HZ / 1000 * SCAN_MS;
   localparam int unsigned AC_EXTRA_MS = 30;
   localparam int unsigned CHANNELS = 8;
   localparam int unsigned VOLT_W = 12;
   localparam int unsigned MV_W = 19;
   localparam int unsigned HOLD_W = 21;
   localparam int unsigned TALLY_W = 32;
   localparam logic [VOLT_W-1:0] PICKUP_RESET = 12'h370;
   localparam logic [VOLT_W-1:0] DROPOUT_RESET = 12'h258;
   localparam logic [HOLD_W-1:0] HOLD_RESET = 21'h000000;
   localparam logic SENSE_RESET = 1'b0;
   localparam logic AC_RESET = 1'b0;
   localparam logic [TALLY_W-1:0] TALLY_RESET = 32'h00000000;

   typedef struct packed {
      logic channel_sense_select;
      logic alternating_supply_option;
      logic [VOLT_W-1:0] pickup_voltage_level;
      logic [VOLT_W-1:0] dropout_voltage_level;
      logic [HOLD_W-1:0] pickup_hold_time;
      logic [HOLD_W-1:0] dropout_hold_time;
   } iic_cfg_type;

   typedef struct packed {
      logic state;
      logic rise;
      logic [MV_W-1:0] live_channel_voltage;
   } iic_stat_type;
endpackage : iic_pkg

// *** hdl/iic_scan_timer.sv ***
`timescale 1ns/10ps
module iic_scan_timer #(
   parameter int unsigned PERIOD = iic_pkg::SCAN_CYCLES
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   output logic tick_o
);
   import iic_pkg::*;
   initial begin
      if (PERIOD < 2) $error("period too short");
   end
   logic [31:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   always_comb begin
      tick_d = (cnt_q == 32'(PERIOD - 1));
      cnt_d = tick_d ? 32'h00000000 : cnt_q + 32'h00000001;
   end
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tick_o = tick_q;
endmodule : iic_scan_timer

// *** testbench/iic_card_bench.sv ***
`timescale 1ns/10ps
module iic_card_bench;
   import iic_pkg::*;
   typedef struct packed {
      logic sn;
      logic ac;
      logic [20:0] pu;
      logic [20:0] dn;
      logic [18:0] mv;
      logic [3:0] n;
      logic e;
   } iic_row_type;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [CHANNELS*MV_W-1:0] volts = '0;
   logic [CHANNELS*MV_W-1:0] mv;
   iic_cfg_type [CHANNELS-1:0] cfg;
   logic [CHANNELS-1:0] clr = '0;
   logic [CHANNELS-1:0] st;
   logic [CHANNELS-1:0] rise;
   int rises [CHANNELS] = '{default: 0};
   logic [CHANNELS*MV_W-1:0] live;
   logic [CHANNELS*TALLY_W-1:0] tally;
   logic [7:0] first;
   logic tick;
   int n_errors = 0;
   int compares = 0;
   int tex;
   int cyc;
   logic prev;
   iic_row_type rows [17] = '{
      '{0, 0, 0, 0, 19'h15F90, 1, 1},
      '{0, 0, 0, 0, 19'h11170, 2, 1},
      '{0, 0, 0, 0, 19'h0C350, 1, 0},
      '{0, 0, 0, 0, 19'h11170, 1, 0},
      '{1, 0, 0, 0, 19'h0C350, 1, 1},
      '{1, 0, 0, 0, 19'h15F90, 1, 0},
      '{0, 0, 10, 0, 19'h15F90, 2, 0},
      '{0, 0, 10, 0, 19'h15F90, 1, 1},
      '{0, 0, 0, 5, 19'h0C350, 1, 1},
      '{0, 0, 0, 5, 19'h0C350, 1, 0},
      '{0, 0, 10, 0, 19'h15F90, 1, 0},
      '{0, 0, 10, 0, 19'h0C350, 1, 0},
      '{0, 0, 10, 0, 19'h15F90, 2, 0},
      '{0, 0, 10, 0, 19'h15F90, 1, 1},
      '{0, 1, 0, 0, 19'h07530, 8, 1},
      '{0, 1, 0, 0, 19'h01388, 6, 1},
      '{0, 1, 0, 0, 19'h01388, 1, 0}};

   iic_field #(.W(CHANNELS*MV_W)) u_iic_field (.mclk_i(mclk), .volts_i(volts),
      .channel_mv_o(mv));
   iic_card #(.SCAN_PERIOD(20), .FIRST_INDEX(8)) u_iic_card (.mclk_i(mclk),
      .arst_n_i(arst_n), .channel_mv_i(mv), .cfg_i(cfg), .tally_reset_command_i(clr),
      .input_channel_n_o(st), .rise_o(rise), .live_channel_voltage_o(live),
      .rising_edge_tally_o(tally), .first_channel_number_o(first), .scan_tick_o(tick));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk32

   task automatic apply(input iic_row_type r);
      @(posedge mclk);
      for (int g = 0; g < CHANNELS; g++) begin
         cfg[g] <= '{r.sn, r.ac, PICKUP_RESET, DROPOUT_RESET, r.pu, r.dn};
      end
      volts <= {CHANNELS{r.mv}};
   endtask : apply

   task automatic wait_ticks(input int n);
      repeat (n) @(posedge mclk iff tick);
      @(posedge mclk);
      #1;
   endtask : wait_ticks

   task automatic close_out();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   initial begin
      forever #5 mclk = ~mclk;
   end

   // count one-cycle rise pulses per channel
   always @(posedge mclk) begin
      for (int g = 0; g < CHANNELS; g++) begin
         if (rise[g] === 1'b1) rises[g]++;
      end
   end

   initial begin
      #200000;
      n_errors++;
      close_out();
   end

   initial begin
      for (int g = 0; g < CHANNELS; g++) begin
         cfg[g] = '{SENSE_RESET, AC_RESET, PICKUP_RESET, DROPOUT_RESET, HOLD_RESET, HOLD_RESET};
      end
      repeat (12) @(posedge mclk);
      chk8(st, 8'h00);
      chk32(tally[31:0], 32'h00000000);
      arst_n <= 1'b1;
      @(posedge mclk iff tick);
      cyc = 0;
      do begin
         @(posedge mclk);
         cyc++;
      end while (tick !== 1'b1);
      chk32(cyc, 32'h00000014);
      chk8(first, 8'h09);
      tex = 0;
      prev = 1'b0;
      foreach (rows[i]) begin
         apply(rows[i]);
         wait_ticks(rows[i].n);
         if (rows[i].e && !prev) tex++;
         prev = rows[i].e;
         chk8(st, {CHANNELS{rows[i].e}});
         for (int g = 0; g < CHANNELS; g++) chk32(tally[g*TALLY_W+:TALLY_W], tex);
         chk32(32'(live[MV_W-1:0]), 32'(rows[i].mv));
      end
      // pickup levels 85 V to 92 V in 1 V steps against 90 V
      @(posedge mclk);
      for (int g = 0; g < CHANNELS; g++) begin
         cfg[g] <= '{1'b0, 1'b0, 12'h352 + 12'(g * 10), DROPOUT_RESET, HOLD_RESET, HOLD_RESET};
      end
      volts <= {CHANNELS{19'h15F90}};
      wait_ticks(1);
      chk8(st, 8'h1F);
      @(posedge mclk);
      clr <= 8'h0F;
      repeat (4) @(posedge mclk);
      #1;
      for (int g = 0; g < CHANNELS; g++) chk32(tally[g*TALLY_W+:TALLY_W], g < 4 ? 0 : tex + (g < 5));
      for (int g = 0; g < CHANNELS; g++) chk32(rises[g], tex + (g < 5));
      close_out();
   end
endmodule : iic_card_bench

// *** testbench/iic_field.sv ***
`timescale 1ns/10ps
module iic_field #(
   parameter int unsigned W = 152
) (
   input wire logic mclk_i,
   input wire logic [W-1:0] volts_i,
   output logic [W-1:0] channel_mv_o
);
   // field sources settle one clock after being commanded
   always_ff @(posedge mclk_i) begin
      channel_mv_o <= volts_i;
   end
endmodule : iic_field
